/* File: rtl/status_fault_pkg.sv */
// Purpose: Constants for the device status and fault rollup registers.
// Assumes: Registers sit at their own byte offsets on the command link.
// Notes: Shared by the register logic and the testbench.

package status_fault_pkg;

	localparam logic [7:0] ADDR_STATUS = 8'h51;
	localparam logic [7:0] ADDR_ROLLUP = 8'h52;

	// Status field positions
	localparam int ST_ANY_FAULT = 7;
	localparam int ST_CHAIN_LIVE = 6;
	localparam int ST_CHAIN_SEEN = 5;
	localparam int ST_LINK_CLEAR = 4;
	localparam int ST_LINK_RESET = 3;
	localparam int ST_FRESH = 1;
	localparam int ST_INIT = 0;

	// Rollup layout: category k sits at bit ROLLUP_LSB + (NUM_CAT-1-k)
	localparam int NUM_CAT = 10;
	localparam int ROLLUP_LSB = 6;
	localparam int CAT_W = 16;

	// Categories that self-clear in nonsticky mode: cell and aux thresholds
	localparam logic [NUM_CAT-1:0] SELF_CLR_CATS = 10'h00F;

	localparam logic RST_INIT_IN_PROGRESS = 1'b1;
	localparam logic [15:0] RST_RD_DATA = 16'h0000;

endpackage : status_fault_pkg

/* File: rtl/fault_cat_if.sv */
// Purpose: Carries category fault conditions, clears and rollup flags.
// Assumes: One clock domain.
// Notes: ctrl side is the register logic, bank side holds the faults.
`timescale 1ns/100ps

interface fault_cat_if #(
	parameter int N = 10,
	parameter int W = 16
);
	logic [N*W-1:0] cond;
	logic [N-1:0] clr;
	logic nonsticky;
	logic [N-1:0] any;

	modport ctrl (output cond, output clr, output nonsticky, input any);
	modport bank (input cond, input clr, input nonsticky, output any);
endinterface : fault_cat_if

/* File: rtl/fault_category_bank.sv */
// Purpose: Holds individual fault bits of every category.
// Assumes: Conditions are levels, clears are one-cycle pulses.
// Notes: A condition present during a clear keeps its bit set.
`timescale 1ns/100ps

module fault_category_bank #(
	parameter int N = 10,
	parameter int W = 16,
	parameter logic [N-1:0] SELF_CLR = '0
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	fault_cat_if.bank cat
);

	initial begin
		if (N < 1 || W < 1) begin
			$error("fault_category_bank needs N and W of at least one");
		end
	end

	// -------------------------------------------------------------
	// Per category fault bits
	// -------------------------------------------------------------
	for (genvar k = 0; k < N; k++) begin : g_cat
		logic [W-1:0] bits_r;
		logic [W-1:0] bits_nxt;
		logic [W-1:0] cond_k;

		assign cond_k = cat.cond[k*W +: W];

		always_comb begin
			if (cat.nonsticky && SELF_CLR[k]) begin
				bits_nxt = cond_k;
			end else if (cat.clr[k]) begin
				bits_nxt = cond_k;
			end else begin
				bits_nxt = bits_r | cond_k;
			end
		end

		always_ff @(posedge i_clk or negedge i_rst_b) begin
			if (!i_rst_b) begin
				bits_r <= '0;
			end else begin
				bits_r <= bits_nxt;
			end
		end

		assign cat.any[k] = |bits_r;

		property p_selfclr;
			@(posedge i_clk) disable iff (!i_rst_b)
			(cat.nonsticky && SELF_CLR[k] && cond_k == '0)
				|=> (bits_r == '0);
		endproperty
		a_selfclr: assert property (p_selfclr)
			else $error("nonsticky fault bits did not self-clear");

		property p_catclr;
			@(posedge i_clk) disable iff (!i_rst_b)
			(cat.clr[k] && !$past(cat.nonsticky) && cond_k == '0)
				|=> (bits_r == '0);
		endproperty
		a_catclr: assert property (p_catclr)
			else $error("category clear left fault bits set");
	end

endmodule : fault_category_bank

/* File: rtl/status_fault_regs.sv */
// Purpose: Device status and fault category rollup registers.
// Assumes: Command decoder gives one-cycle read and write strobes.
// Notes: Read data appears one cycle after the read strobe.
`timescale 1ns/100ps

module status_fault_regs #(
	parameter int N = status_fault_pkg::NUM_CAT,
	parameter int W = status_fault_pkg::CAT_W
) (
	input wire logic I_MCLK,
	input wire logic I_RST_B,
	input wire logic i_REG_WR,
	input wire logic i_REG_RD,
	input wire logic [7:0] i_REG_ADDR,
	input wire logic [15:0] i_REG_WDATA,
	input wire logic i_CHAIN_FAULT,
	input wire logic i_CHAIN_FAULT_EN,
	input wire logic i_NONSTICKY_FAULT_MODE,
	input wire logic i_LINK_CLEAR_EVT,
	input wire logic i_LINK_RESET_EVT,
	input wire logic i_SAMPLE_DONE,
	input wire logic i_SAMPLE_AUTO_TEMP,
	input wire logic i_RESULT_READ,
	input wire logic i_INIT_DONE,
	input wire logic [N*W-1:0] i_FAULT_COND,
	output logic [15:0] o_RD_DATA,
	output logic o_RD_VALID,
	output logic o_FAULT,
	output logic o_INIT_IN_PROGRESS,
	output logic o_SKIP_SUPPLY_WAIT
);

	initial begin
		if (N != status_fault_pkg::NUM_CAT || W < 1) begin
			$error("status_fault_regs needs ten categories and W >= 1");
		end
	end

	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_B);

	// -------------------------------------------------------------
	// Decode
	// -------------------------------------------------------------
	logic wr_status;
	logic wr_rollup;

	assign wr_status = i_REG_WR && (i_REG_ADDR == status_fault_pkg::ADDR_STATUS);
	assign wr_rollup = i_REG_WR && (i_REG_ADDR == status_fault_pkg::ADDR_ROLLUP);

	// -------------------------------------------------------------
	// Fault category bank
	// -------------------------------------------------------------
	fault_cat_if #(.N(N), .W(W)) cat_bus ();
	logic [N-1:0] cat_clr;

	// Rollup bit 15 is category 0, so the write data is reversed
	always_comb begin
		for (int k = 0; k < N; k++) begin
			cat_clr[k] = wr_rollup &&
				i_REG_WDATA[status_fault_pkg::ROLLUP_LSB + N - 1 - k];
		end
	end

	assign cat_bus.cond = i_FAULT_COND;
	assign cat_bus.clr = cat_clr;
	assign cat_bus.nonsticky = i_NONSTICKY_FAULT_MODE;

	fault_category_bank #(
		.N(N),
		.W(W),
		.SELF_CLR(status_fault_pkg::SELF_CLR_CATS)
	) u_bank (
		.i_clk(I_MCLK),
		.i_rst_b(I_RST_B),
		.cat(cat_bus)
	);

	logic [15:0] rollup;

	always_comb begin
		rollup = 16'h0000;
		for (int k = 0; k < N; k++) begin
			rollup[status_fault_pkg::ROLLUP_LSB + N - 1 - k] = cat_bus.any[k];
		end
	end

	// -------------------------------------------------------------
	// Chain fault
	// -------------------------------------------------------------
	logic chain_live;
	logic chain_seen_r;

	assign chain_live = i_CHAIN_FAULT && i_CHAIN_FAULT_EN;

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			chain_seen_r <= 1'b0;
		end else if (chain_live) begin
			chain_seen_r <= 1'b1;
		end else if (wr_status && i_REG_WDATA[status_fault_pkg::ST_CHAIN_SEEN]) begin
			chain_seen_r <= 1'b0;
		end
	end

	// -------------------------------------------------------------
	// Link events
	// -------------------------------------------------------------
	logic link_clear_seen_r;
	logic link_reset_seen_r;

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			link_clear_seen_r <= 1'b0;
		end else if (i_LINK_CLEAR_EVT) begin
			link_clear_seen_r <= 1'b1;
		end else if (wr_status && i_REG_WDATA[status_fault_pkg::ST_LINK_CLEAR]) begin
			link_clear_seen_r <= 1'b0;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			link_reset_seen_r <= 1'b0;
		end else if (i_LINK_RESET_EVT) begin
			link_reset_seen_r <= 1'b1;
		end else if (wr_status && i_REG_WDATA[status_fault_pkg::ST_LINK_RESET]) begin
			link_reset_seen_r <= 1'b0;
		end
	end

	// -------------------------------------------------------------
	// Initialization and fresh sample
	// -------------------------------------------------------------
	logic init_r;
	logic fresh_r;
	logic fresh_set;
	logic skip_r;

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			init_r <= status_fault_pkg::RST_INIT_IN_PROGRESS;
		end else if (i_INIT_DONE) begin
			init_r <= 1'b0;
		end
	end

	// Skip request is a pulse; the sequencer decides if init still waits
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			skip_r <= 1'b0;
		end else begin
			skip_r <= wr_status && init_r &&
				i_REG_WDATA[status_fault_pkg::ST_INIT];
		end
	end

	assign fresh_set = i_SAMPLE_DONE && !i_SAMPLE_AUTO_TEMP && !init_r;

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			fresh_r <= 1'b0;
		end else if (fresh_set) begin
			fresh_r <= 1'b1;
		end else if (i_RESULT_READ) begin
			fresh_r <= 1'b0;
		end
	end

	// -------------------------------------------------------------
	// Status word, fault output, read port
	// -------------------------------------------------------------
	logic any_fault;
	logic [7:0] status;

	assign any_fault = |rollup;

	always_comb begin
		status = 8'h00;
		status[status_fault_pkg::ST_ANY_FAULT] = any_fault;
		status[status_fault_pkg::ST_CHAIN_LIVE] = chain_live;
		status[status_fault_pkg::ST_CHAIN_SEEN] = chain_seen_r && i_CHAIN_FAULT_EN;
		status[status_fault_pkg::ST_LINK_CLEAR] = link_clear_seen_r;
		status[status_fault_pkg::ST_LINK_RESET] = link_reset_seen_r;
		status[status_fault_pkg::ST_FRESH] = fresh_r;
		status[status_fault_pkg::ST_INIT] = init_r;
	end

	// Informational bits stay out of the fault output
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			o_FAULT <= 1'b0;
		end else begin
			o_FAULT <= any_fault || chain_live;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			o_RD_DATA <= status_fault_pkg::RST_RD_DATA;
			o_RD_VALID <= 1'b0;
		end else begin
			o_RD_VALID <= i_REG_RD;
			if (!i_REG_RD) begin
				o_RD_DATA <= status_fault_pkg::RST_RD_DATA;
			end else if (i_REG_ADDR == status_fault_pkg::ADDR_STATUS) begin
				o_RD_DATA <= {8'h00, status};
			end else if (i_REG_ADDR == status_fault_pkg::ADDR_ROLLUP) begin
				o_RD_DATA <= rollup;
			end else begin
				o_RD_DATA <= status_fault_pkg::RST_RD_DATA;
			end
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			o_INIT_IN_PROGRESS <= status_fault_pkg::RST_INIT_IN_PROGRESS;
			o_SKIP_SUPPLY_WAIT <= 1'b0;
		end else begin
			o_INIT_IN_PROGRESS <= init_r;
			o_SKIP_SUPPLY_WAIT <= skip_r;
		end
	end

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	property p_anyfault;
		i_REG_RD && i_REG_ADDR == status_fault_pkg::ADDR_STATUS
			|=> o_RD_DATA[status_fault_pkg::ST_ANY_FAULT] == $past(|cat_bus.any);
	endproperty
	a_anyfault: assert property (p_anyfault)
		else $error("any-fault bit does not match the categories");

	property p_chainmask;
		!i_CHAIN_FAULT_EN && i_REG_RD &&
			i_REG_ADDR == status_fault_pkg::ADDR_STATUS
			|=> o_RD_DATA[6:5] == 2'b00;
	endproperty
	a_chainmask: assert property (p_chainmask)
		else $error("chain fault bits not masked");

	property p_faultout;
		(i_CHAIN_FAULT && i_CHAIN_FAULT_EN) |=> o_FAULT;
	endproperty
	a_faultout: assert property (p_faultout)
		else $error("live chain fault missing from fault output");

	property p_infoonly;
		(!i_CHAIN_FAULT_EN && cat_bus.any == '0) |=> !o_FAULT;
	endproperty
	a_infoonly: assert property (p_infoonly)
		else $error("informational bits drove the fault output");

	property p_seenhold;
		(chain_seen_r && !wr_status) |=> chain_seen_r;
	endproperty
	a_seenhold: assert property (p_seenhold)
		else $error("latched chain fault dropped without a clear");

	property p_linkclr;
		(wr_status && i_REG_WDATA[4] && !i_LINK_CLEAR_EVT)
			|=> !link_clear_seen_r;
	endproperty
	a_linkclr: assert property (p_linkclr)
		else $error("link clear flag not cleared by write one");

	property p_linkrst;
		i_LINK_RESET_EVT |=> link_reset_seen_r;
	endproperty
	a_linkrst: assert property (p_linkrst)
		else $error("link reset event not recorded");

	property p_fresh;
		(i_SAMPLE_DONE && (i_SAMPLE_AUTO_TEMP || init_r) && !fresh_r)
			|=> !fresh_r;
	endproperty
	a_fresh: assert property (p_fresh)
		else $error("fresh sample set by internal sampling");

	property p_freshclr;
		(i_RESULT_READ && !fresh_set) |=> ##1 !o_RD_DATA[1] || !o_RD_VALID;
	endproperty
	a_freshclr: assert property (p_freshclr)
		else $error("fresh sample survived a result read");

	property p_skip;
		(wr_status && i_REG_WDATA[0] && init_r) |-> ##2 o_SKIP_SUPPLY_WAIT;
	endproperty
	a_skip: assert property (p_skip)
		else $error("supply wait skip not issued");

	property p_rsvd;
		i_REG_RD |=> (o_RD_VALID && o_RD_DATA[5:0] == 6'h00) ||
			$past(i_REG_ADDR) != status_fault_pkg::ADDR_ROLLUP;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("rollup reserved bits not zero");

endmodule : status_fault_regs

/* File: sim/host_model.sv */
// Purpose: Host side of the register port; issues reads and writes.
// Assumes: Strobes are taken on the rising clock edge, one cycle wide.
// Notes: Bounded wait for the answer; a missing answer returns ok = 0.
`timescale 1ns/100ps

module host_model (
	input wire logic i_clk,
	input wire logic i_rd_valid,
	input wire logic [15:0] i_rd_data,
	output logic o_wr,
	output logic o_rd,
	output logic [7:0] o_addr,
	output logic [15:0] o_wdata
);
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 8'h00;
		o_wdata = 16'h0000;
	end

	// Released lines show the inverse so stale values never look valid
	task automatic do_write(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask : do_write

	task automatic do_read(input logic [7:0] a, output logic [15:0] d,
		output bit ok);
		ok = 1'b0;
		d = 16'h0000;
		@(posedge i_clk);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(posedge i_clk);
			if (i_rd_valid === 1'b1) begin
				d = i_rd_data;
				ok = 1'b1;
			end
		end
	endtask : do_read
endmodule : host_model

/* File: sim/tb_status_fault_regs.sv */
// Purpose: Self-checking bench for the status and rollup registers.
// Assumes: Reference model kept in integers, updated with the stimulus.
// Notes: Every read and the fault output are compared with the model.
`timescale 1ns/100ps

module tb_status_fault_regs;
	localparam logic [7:0] A_ST = status_fault_pkg::ADDR_STATUS;
	localparam logic [7:0] A_RO = status_fault_pkg::ADDR_ROLLUP;
	logic I_MCLK, I_RST_B, wr, rd, fault_in, fault_en, nonsticky;
	logic [7:0] addr;
	logic [15:0] wdata, rd_data;
	logic rd_valid, fault_out, init_out, skip;
	logic [5:0] ev;
	logic [159:0] cond;
	int num_errors, samples_checked, n, seed;
	int held [10];
	int m_seen, m_clr, m_rst, m_fresh, m_init;

	status_fault_regs u_status_fault_regs (.I_MCLK(I_MCLK),
		.I_RST_B(I_RST_B), .i_REG_WR(wr), .i_REG_RD(rd), .i_REG_ADDR(addr),
		.i_REG_WDATA(wdata), .i_CHAIN_FAULT(fault_in),
		.i_CHAIN_FAULT_EN(fault_en), .i_NONSTICKY_FAULT_MODE(nonsticky),
		.i_LINK_CLEAR_EVT(ev[4]), .i_LINK_RESET_EVT(ev[3]),
		.i_SAMPLE_DONE(ev[1]), .i_SAMPLE_AUTO_TEMP(ev[5]),
		.i_RESULT_READ(ev[2]), .i_INIT_DONE(ev[0]), .i_FAULT_COND(cond),
		.o_RD_DATA(rd_data), .o_RD_VALID(rd_valid), .o_FAULT(fault_out),
		.o_INIT_IN_PROGRESS(init_out), .o_SKIP_SUPPLY_WAIT(skip));

	host_model host (.i_clk(I_MCLK), .i_rd_valid(rd_valid),
		.i_rd_data(rd_data), .o_wr(wr), .o_rd(rd), .o_addr(addr),
		.o_wdata(wdata));

	// ----------------------------------------
	// Reference model and checking
	// ----------------------------------------
	function automatic logic [15:0] exp_roll();
		logic [15:0] r;
		r = 16'h0000;
		for (int k = 0; k < 10; k++)
			if (held[k] != 0) r[15-k] = 1'b1;
		return r;
	endfunction : exp_roll

	function automatic logic [15:0] exp_stat();
		logic [15:0] s;
		s = 16'h0000;
		s[7] = exp_roll() != 16'h0000;
		s[6] = fault_in & fault_en;
		s[5] = (m_seen != 0) & fault_en;
		s[4] = m_clr != 0;
		s[3] = m_rst != 0;
		s[1] = m_fresh != 0;
		s[0] = m_init != 0;
		return s;
	endfunction : exp_stat

	task automatic wrap_up();
		if (num_errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] s);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		bit ok;
		host.do_read(a, d, ok);
		if (!ok) begin
			num_errors++;
			wrap_up();
		end else begin
			chk(a == A_ST ? "status" : "reg", e, d);
		end
	endtask : rd_chk

	task automatic chk_fault();
		logic e;
		e = (exp_roll() != 16'h0000) | (fault_in & fault_en);
		chk("fault_out", {15'h0000, e}, {15'h0000, fault_out});
	endtask : chk_fault

	task automatic pulse(input logic [5:0] m);
		@(posedge I_MCLK);
		ev <= m;
		@(posedge I_MCLK);
		ev <= 6'h00;
	endtask : pulse

	task automatic settle();
		repeat (3) @(posedge I_MCLK);
	endtask : settle

	initial begin
		I_MCLK = 1'b0;
		forever #2.5 I_MCLK = ~I_MCLK;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		I_RST_B = 1'b0;
		{fault_in, nonsticky, ev, cond} = '0;
		fault_en = 1'b1;
		{num_errors, samples_checked, m_seen, m_clr, m_rst, m_fresh} = '0;
		m_init = 1;
		foreach (held[k]) held[k] = 0;
		seed = $urandom(68);
		repeat (2) @(posedge I_MCLK);
		I_RST_B <= 1'b1;
		rd_chk(A_ST, exp_stat());
		chk("init_out", 16'h0001, {15'h0000, init_out});
		rd_chk(A_RO, exp_roll());
		rd_chk(8'h60, 16'h0000);
		// Sample during init must not mark fresh data
		pulse(6'h02);
		rd_chk(A_ST, exp_stat());
		host.do_write(A_ST, 16'h0001);
		n = 0;
		repeat (4) begin
			@(posedge I_MCLK);
			if (skip === 1'b1) n++;
		end
		chk("skip", 16'h0001, 16'(n));
		pulse(6'h01);
		m_init = 0;
		settle();
		rd_chk(A_ST, exp_stat());
		chk("init_out", 16'h0000, {15'h0000, init_out});
		pulse(6'h18);
		{m_clr, m_rst} = {32'd1, 32'd1};
		// Auto temperature sample must leave fresh clear
		pulse(6'h22);
		rd_chk(A_ST, exp_stat());
		pulse(6'h02);
		m_fresh = 1;
		rd_chk(A_ST, exp_stat());
		chk_fault();
		host.do_write(A_ST, 16'h0000);
		rd_chk(A_ST, exp_stat());
		host.do_write(A_ST, 16'h00FF);
		{m_clr, m_rst} = '0;
		rd_chk(A_ST, exp_stat());
		pulse(6'h04);
		m_fresh = 0;
		rd_chk(A_ST, exp_stat());
		@(posedge I_MCLK);
		fault_in <= 1'b1;
		m_seen = 1;
		settle();
		rd_chk(A_ST, exp_stat());
		chk_fault();
		fault_in <= 1'b0;
		settle();
		rd_chk(A_ST, exp_stat());
		chk_fault();
		host.do_write(A_ST, 16'h0000);
		rd_chk(A_ST, exp_stat());
		// Latched bit is still set here, so the mask is really exercised
		fault_en <= 1'b0;
		fault_in <= 1'b1;
		settle();
		rd_chk(A_ST, exp_stat());
		chk_fault();
		fault_in <= 1'b0;
		fault_en <= 1'b1;
		settle();
		rd_chk(A_ST, exp_stat());
		host.do_write(A_ST, 16'h0020);
		m_seen = 0;
		rd_chk(A_ST, exp_stat());
		for (int k = 0; k < 10; k++) begin
			@(posedge I_MCLK);
			nonsticky <= k[0];
			cond[k*16 +: 16] <= 16'h0001 << ($urandom % 16);
			held[k] = 1;
			settle();
			rd_chk(A_RO, exp_roll());
			rd_chk(A_ST, exp_stat());
			chk_fault();
			cond[k*16 +: 16] <= 16'h0000;
			settle();
			if (k[0] && k < 4) held[k] = 0;
			rd_chk(A_RO, exp_roll());
			host.do_write(A_RO, 16'h003F | 16'(1 << (15 - k)));
			held[k] = 0;
			rd_chk(A_RO, exp_roll());
		end
		// Reset in mid-run drops event flags and restarts init
		pulse(6'h08);
		@(posedge I_MCLK);
		I_RST_B <= 1'b0;
		{m_rst, m_init} = {32'd0, 32'd1};
		repeat (2) @(posedge I_MCLK);
		I_RST_B <= 1'b1;
		rd_chk(A_ST, exp_stat());
		chk("init_out", 16'h0001, {15'h0000, init_out});
		chk_fault();
		wrap_up();
	end
endmodule : tb_status_fault_regs
